// file: rtl/tic_pkg.sv
package tic_pkg;

  // ----------------------------------------------------------------
  // host byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_HOST_SEND_PORT = 4'h1;
  localparam logic [3:0] OFS_TIMER_A_COUNT = 4'h4;
  localparam logic [3:0] OFS_TIMER_B_COUNT = 4'h5;
  localparam logic [3:0] OFS_TIMER_B_PRESCALE = 4'h6;
  localparam logic [3:0] OFS_COUNTER_CONTROL_WORD = 4'h7;
  localparam logic [3:0] OFS_IRQ_CONTROL = 4'h8;
  localparam logic [3:0] OFS_IRQ_CONTROL_LAST = 4'hb;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'hc;
  localparam logic [3:0] OFS_IRQ_STATUS_LAST = 4'hf;

  // ----------------------------------------------------------------
  // counter control word fields
  // ----------------------------------------------------------------
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_RW_HI = 5;
  localparam int CW_RW_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam logic [1:0] CW_RW_LATCH = 2'h0;
  localparam logic [1:0] CW_RW_LOHI = 2'h3;
  localparam logic [2:0] CW_MODE_SQUARE = 3'h3;
  localparam logic [2:0] CW_MODE_SQUARE_ALT = 3'h7;

  // ----------------------------------------------------------------
  // register layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_bus_drive;
    logic global_irq_unmask;
    logic unused5;
    logic send_ninth_bit;
    logic timer_b_irq_en;
    logic timer_a_irq_en;
    logic timer_b_irq_clear_n;
    logic timer_a_irq_clear_n;
  } tic_ctrl_type;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_ANY_BIT = 7;
  localparam int STAT_B_BIT = 1;
  localparam int STAT_A_BIT = 0;

  typedef enum logic [0:0] {
    TIC_RATE = 1'b0,
    TIC_SQUARE = 1'b1
  } tic_mode_type;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int TICK_A_NS = 2000;
  localparam int TICK_B_NS = 500;
  localparam int TICK_A_CYC = (TICK_A_NS * CLK_KHZ) / 1000000;
  localparam int TICK_B_CYC = (TICK_B_NS * CLK_KHZ) / 1000000;
  localparam int NUM_COUNTERS = 3;
  localparam int IRQ_LEVEL_MIN = 2;
  localparam int IRQ_LEVELS = 6;

endpackage

// file: rtl/tic_counter.sv
`timescale 1ns/1ps
`default_nettype none

module tic_counter import tic_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // count input
  input wire logic tick,
  // host side
  input wire logic mode_wr,
  input wire tic_mode_type mode,
  input wire logic latch,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // outputs
  output logic out,
  output logic term
);

  logic [W-1:0] reload_q;
  logic [W-1:0] count_q;
  logic [W-1:0] hold_q;
  logic held_q;
  logic wr_hi_q;
  logic rd_hi_q;
  logic armed_q;
  logic out_q;
  logic term_q;
  tic_mode_type mode_q;
  logic [W-1:0] src;

  // ----------------------------------------------------------------
  // load and count
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= '0;
      count_q <= '0;
      wr_hi_q <= 1'b0;
      armed_q <= 1'b0;
      out_q <= 1'b1;
      term_q <= 1'b0;
      mode_q <= TIC_RATE;
    end else begin
      term_q <= 1'b0;
      if (mode_wr) begin
        mode_q <= mode;
        wr_hi_q <= 1'b0;
        armed_q <= 1'b0;
        out_q <= 1'b1;
      end else if (wr_stb) begin
        // low byte first, high byte completes the count (see RL8)
        if (!wr_hi_q) begin
          reload_q[7:0] <= wdata;
          wr_hi_q <= 1'b1;
        end else begin
          reload_q[W-1:8] <= wdata;
          count_q <= {wdata, reload_q[7:0]};
          wr_hi_q <= 1'b0;
          armed_q <= 1'b1;
        end
      end else if (armed_q && tick) begin
        if (mode_q == TIC_RATE) begin
          // rate generator: one low input period, reload at 1 (see RL2)
          if (count_q <= W'(1)) begin
            count_q <= reload_q;
            term_q <= 1'b1;
            out_q <= 1'b1;
          end else begin
            count_q <= count_q - W'(1);
            out_q <= (count_q != W'(2));
          end
        end else begin
          // square wave: count by two, odd counts lose one tick (see RL4)
          if (count_q <= W'(2)) begin
            count_q <= {reload_q[W-1:1], 1'b0};
            out_q <= ~out_q;
            term_q <= out_q;
          end else begin
            count_q <= count_q - W'(2);
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // latch and read back
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
      held_q <= 1'b0;
      rd_hi_q <= 1'b0;
    end else begin
      if (mode_wr) begin
        held_q <= 1'b0;
        rd_hi_q <= 1'b0;
      end else if (latch && !held_q) begin
        hold_q <= count_q; // see RL7
        held_q <= 1'b1;
        rd_hi_q <= 1'b0;
      end else if (rd_stb) begin
        rd_hi_q <= ~rd_hi_q; // see RL8
        if (rd_hi_q) begin
          held_q <= 1'b0;
        end
      end
    end
  end

  assign src = held_q ? hold_q : count_q;
  assign rdata = rd_hi_q ? src[W-1:8] : src[7:0];
  assign out = out_q;
  assign term = term_q;

endmodule

`default_nettype wire

// file: rtl/tic_timer_irq.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1 - timer B counter steps on each rising prescaler output; interval is B*P*0.5us.
// RL2 - timer B counter is a rate generator taking reloads 2 to 65535.
// RL3 - timer B terminal event raises timer B source, status bit 1, line.
// RL4 - prescaler runs as square-wave generator, reloads 2 to 65535, driving timer B.
// RL5 - control words 34, 74, b6 set modes 2, 2, 3, 16-bit binary.
// RL6 - software sets each counter mode before using the timers.
// RL7 - control words 00, 40, 80 capture counter 0, 1, 2 for reading.
// RL8 - counter bytes move low first then high; reads done with interrupts off.
// RL9 - control bits 0,1 are active-low timer clears, reset 0, pulsed low.
// RL10 - control bits 2,3 enable timer A, B interrupts; reset 0.
// RL11 - control bit 4 is bit 8 of the word sent with send port byte.
// RL12 - global unmask bit, reset 0, blocks all card requests when 0.
// RL13 - bus-drive bit, reset 0, drives line when 1, floats it when 0.
// RL14 - software sets bus-drive before the global unmask bit.
// RL15 - service routine masks, services, clears, sends end-of-interrupt, unmasks.
// RL16 - status bits 0,1 show pending timer A, B requests until cleared.
// RL17 - status bit 7 is set while any of the four sources requests; the code counts timer A, B there only while their enables are set.
// RL18 - four sources merge onto one line chosen by jumper among 2 to 7.
// RL19 - request reaches system only with bus-drive, unmask and own enable set.
// RL20 - timer A is counter 0, rate generator at 2us ticks, status bit 0.
// RL21 - offsets 9 to b mirror control, d to f mirror status.
// RL22 - timer requests latch on terminal event, held until clear, enable-independent.
module tic_timer_irq import tic_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host byte port
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // parallel interface unit side
  input wire logic host_send_ready,
  input wire logic host_receive_ready,
  output logic [8:0] send_word,
  output logic send_stb,
  // system interrupt lines, levels 2 to 7
  input wire logic [2:0] irq_level_sel,
  output logic [IRQ_LEVELS-1:0] irq_line,
  output logic [IRQ_LEVELS-1:0] irq_line_oe
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [7:0] div_a_q;
  logic [7:0] div_b_q;
  logic tick_a_q;
  logic tick_b_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_a_q <= '0;
      tick_a_q <= 1'b0;
    end else begin
      tick_a_q <= (div_a_q == 8'(TICK_A_CYC - 1));
      div_a_q <= (div_a_q == 8'(TICK_A_CYC - 1)) ? 8'h00 : div_a_q + 8'h01; // see RL20
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_b_q <= '0;
      tick_b_q <= 1'b0;
    end else begin
      tick_b_q <= (div_b_q == 8'(TICK_B_CYC - 1));
      div_b_q <= (div_b_q == 8'(TICK_B_CYC - 1)) ? 8'h00 : div_b_q + 8'h01; // see RL1
    end
  end

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  logic cw_wr;
  logic ctrl_sel;
  logic stat_sel;
  logic [1:0] cw_counter;
  logic [1:0] cw_rw;
  tic_mode_type cw_mode;

  assign cw_wr = host_wr && (host_addr == OFS_COUNTER_CONTROL_WORD);
  assign ctrl_sel = host_addr inside {[OFS_IRQ_CONTROL:OFS_IRQ_CONTROL_LAST]}; // see RL21
  assign stat_sel = host_addr inside {[OFS_IRQ_STATUS:OFS_IRQ_STATUS_LAST]}; // see RL21
  assign cw_counter = host_wdata[CW_SEL_HI:CW_SEL_LO];
  assign cw_rw = host_wdata[CW_RW_HI:CW_RW_LO];
  // modes 3 and 7 select the square wave; every other mode runs as rate generator
  assign cw_mode = ((host_wdata[CW_MODE_HI:CW_MODE_LO] == CW_MODE_SQUARE) ||
                    (host_wdata[CW_MODE_HI:CW_MODE_LO] == CW_MODE_SQUARE_ALT)) ?
                   TIC_SQUARE : TIC_RATE;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  logic [NUM_COUNTERS-1:0] cnt_tick;
  logic [NUM_COUNTERS-1:0] cnt_out;
  logic [NUM_COUNTERS-1:0] cnt_term;
  logic [7:0] cnt_rdata [NUM_COUNTERS];
  logic presc_out_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_out_q <= 1'b1;
    end else begin
      presc_out_q <= cnt_out[2];
    end
  end

  assign cnt_tick[0] = tick_a_q;
  assign cnt_tick[1] = cnt_out[2] && !presc_out_q; // see RL1
  assign cnt_tick[2] = tick_b_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      tic_counter #(.W(W)) u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .tick(cnt_tick[gi]),
        .mode_wr(cw_wr && (cw_counter == 2'(gi)) && (cw_rw == CW_RW_LOHI)), // see RL5
        .mode(cw_mode),
        .latch(cw_wr && (cw_counter == 2'(gi)) && (cw_rw == CW_RW_LATCH)), // see RL7
        .wr_stb(host_wr && (host_addr == OFS_TIMER_A_COUNT + 4'(gi))),
        .rd_stb(host_rd && (host_addr == OFS_TIMER_A_COUNT + 4'(gi))),
        .wdata(host_wdata),
        .rdata(cnt_rdata[gi]),
        .out(cnt_out[gi]),
        .term(cnt_term[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt control register and send port
  // ----------------------------------------------------------------
  tic_ctrl_type ctrl_q;
  logic [8:0] send_word_q;
  logic send_stb_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= tic_ctrl_type'(CTRL_RESET); // see RL9
    end else if (host_wr && ctrl_sel) begin
      ctrl_q <= tic_ctrl_type'(host_wdata); // see RL10
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      send_word_q <= '0;
      send_stb_q <= 1'b0;
    end else begin
      send_stb_q <= host_wr && (host_addr == OFS_HOST_SEND_PORT);
      if (host_wr && (host_addr == OFS_HOST_SEND_PORT)) begin
        send_word_q <= {ctrl_q.send_ninth_bit, host_wdata}; // see RL11
      end
    end
  end

  // ----------------------------------------------------------------
  // pending timer requests
  // ----------------------------------------------------------------
  logic pend_a_q;
  logic pend_b_q;

  // an event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_q <= 1'b0;
    end else if (cnt_term[0]) begin
      pend_a_q <= 1'b1; // see RL22
    end else if (!ctrl_q.timer_a_irq_clear_n) begin
      pend_a_q <= 1'b0; // see RL9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_b_q <= 1'b0;
    end else if (cnt_term[1]) begin
      pend_b_q <= 1'b1; // see RL3
    end else if (!ctrl_q.timer_b_irq_clear_n) begin
      pend_b_q <= 1'b0; // see RL9
    end
  end

  // ----------------------------------------------------------------
  // merge and drive the system line
  // ----------------------------------------------------------------
  logic any_req;
  logic [IRQ_LEVELS-1:0] level_onehot;
  logic [IRQ_LEVELS-1:0] irq_line_q;
  logic [IRQ_LEVELS-1:0] irq_line_oe_q;

  assign any_req = (pend_a_q && ctrl_q.timer_a_irq_en) || (pend_b_q && ctrl_q.timer_b_irq_en) ||
                   host_send_ready || host_receive_ready; // see RL17

  // jumper values below level 2 select no line at all
  always_comb begin
    level_onehot = '0;
    if (irq_level_sel >= 3'(IRQ_LEVEL_MIN)) begin
      level_onehot[3'(irq_level_sel - 3'(IRQ_LEVEL_MIN))] = 1'b1; // see RL18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line_q <= '0;
      irq_line_oe_q <= '0;
    end else begin
      irq_line_q <= (any_req && ctrl_q.global_irq_unmask) ? level_onehot : '0; // see RL12 RL19
      irq_line_oe_q <= ctrl_q.irq_bus_drive ? level_onehot : '0; // see RL13
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] stat_byte;

  assign stat_byte = {any_req, 5'h00, pend_b_q, pend_a_q}; // see RL16

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (host_rd) begin
      if (host_addr == OFS_TIMER_A_COUNT) begin
        rdata_q <= cnt_rdata[0];
      end else if (host_addr == OFS_TIMER_B_COUNT) begin
        rdata_q <= cnt_rdata[1];
      end else if (host_addr == OFS_TIMER_B_PRESCALE) begin
        rdata_q <= cnt_rdata[2];
      end else if (ctrl_sel) begin
        rdata_q <= ctrl_q;
      end else if (stat_sel) begin
        rdata_q <= stat_byte;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign host_rdata = rdata_q;
  assign send_word = send_word_q;
  assign send_stb = send_stb_q;
  assign irq_line = irq_line_q;
  assign irq_line_oe = irq_line_oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // gap counters prove the tick spacing without a long repetition
  logic [7:0] gap_a_q;
  logic [7:0] gap_b_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_a_q <= '0;
      gap_b_q <= '0;
    end else begin
      gap_a_q <= tick_a_q ? 8'h01 : gap_a_q + 8'h01;
      gap_b_q <= tick_b_q ? 8'h01 : gap_b_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pend_a_sets_a: assert property (cnt_term[0] |=> pend_a_q) // see RL22
    else $error("timer A terminal event not latched");
  pend_b_sets_a: assert property (cnt_term[1] |=> pend_b_q && stat_byte[STAT_B_BIT]) // see RL3
    else $error("timer B terminal event not latched");
  clear_a_works_a: assert property (!ctrl_q.timer_a_irq_clear_n && !cnt_term[0] |=> // see RL9
      !pend_a_q)
    else $error("timer A clear ignored");
  clear_b_works_a: assert property (!ctrl_q.timer_b_irq_clear_n && !cnt_term[1] |=> // see RL9
      !pend_b_q)
    else $error("timer B clear ignored");
  hold_a_pend_a: assert property (pend_a_q && ctrl_q.timer_a_irq_clear_n |=> pend_a_q) // see RL22
    else $error("timer A request dropped without clear");
  hold_b_pend_a: assert property (pend_b_q && ctrl_q.timer_b_irq_clear_n |=> pend_b_q) // see RL22
    else $error("timer B request dropped without clear");
  status_read_a: assert property (host_rd && stat_sel |=> // see RL16
      host_rdata == {$past(any_req), 5'h00, $past(pend_b_q), $past(pend_a_q)})
    else $error("status read wrong");
  status_any_a: assert property (host_send_ready || host_receive_ready |-> stat_byte[STAT_ANY_BIT]) // see RL17
    else $error("port source missing from card status");
  line_gate_a: assert property (##1 irq_line == // see RL19
      (($past(any_req) && $past(ctrl_q.global_irq_unmask)) ? $past(level_onehot) : '0))
    else $error("interrupt line gating wrong");
  timer_inhibit_a: assert property (!ctrl_q.timer_a_irq_en && !ctrl_q.timer_b_irq_en && // see RL10
      !host_send_ready && !host_receive_ready |=> irq_line == '0)
    else $error("inhibited timer reached the line");
  bus_line_one_a: assert property ($onehot0(irq_line_oe) && $onehot0(irq_line)) // see RL18
    else $error("more than one system line used");
  line_drive_a: assert property (!ctrl_q.irq_bus_drive |=> irq_line_oe == '0) // see RL13
    else $error("line driven while bus-drive off");
  ninth_bit_a: assert property (host_wr && host_addr == OFS_HOST_SEND_PORT |=> // see RL11
      send_stb && send_word == {$past(ctrl_q.send_ninth_bit), $past(host_wdata)})
    else $error("send word wrong");
  ctrl_alias_a: assert property (host_wr && host_addr == OFS_IRQ_CONTROL_LAST |=> // see RL21
      ctrl_q == $past(host_wdata))
    else $error("control alias not written");
  a_tick_gap_a: assert property (tick_a_q && gap_a_q != 8'h00 |-> // see RL20
      gap_a_q == 8'(TICK_A_CYC))
    else $error("timer A time base spacing wrong");
  b_tick_gap_a: assert property (tick_b_q && gap_b_q != 8'h00 |-> // see RL1
      gap_b_q == 8'(TICK_B_CYC))
    else $error("prescaler time base spacing wrong");
  b_tick_step_a: assert property (tick_b_q |=> !tick_b_q [*8]) // see RL1
    else $error("prescaler time base too fast");
  masked_idle_a: assert property (!ctrl_q.global_irq_unmask |=> irq_line == '0) // see RL12
    else $error("request passed while masked");

  timer_b_cov: cover property (cnt_term[1]);
  presc_cov: cover property (cnt_term[2]);
  irq_rise_cov: cover property (irq_line == '0 ##1 irq_line != '0);
  latch_read_cov: cover property (cw_wr && cw_rw == CW_RW_LATCH ##[1:20] host_rd);
  send_cov: cover property (send_stb && send_word[8]);

endmodule

`default_nettype wire

// file: tb/tic_sys_model.sv
`timescale 1ns/1ps
`default_nettype none

module tic_sys_model import tic_pkg::*; (
  // clock
  input wire logic clk,
  // port unit sources, commanded by the bench
  input wire logic tx_want,
  input wire logic rx_want,
  output logic host_send_ready,
  output logic host_receive_ready,
  // system interrupt side
  input wire logic [2:0] level,
  input wire logic [IRQ_LEVELS-1:0] irq_line,
  input wire logic [IRQ_LEVELS-1:0] irq_line_oe,
  output logic [IRQ_LEVELS-1:0] sys_irq,
  output logic [7:0] edge_cnt
);
  logic [2:0] lv;
  logic prev_q = 1'b0;
  assign lv = level - 3'h2;
  initial begin
    host_send_ready = 1'b0;
    host_receive_ready = 1'b0;
    sys_irq = '0;
    edge_cnt = 8'h00;
  end
  always @(posedge clk) begin
    host_send_ready <= tx_want;
    host_receive_ready <= rx_want;
  end
  // a floated line wanders, so a stale level never reads as a request
  always @(posedge clk) begin
    for (int k = 0; k < IRQ_LEVELS; k++) begin
      sys_irq[k] <= irq_line_oe[k] ? irq_line[k] : ~sys_irq[k];
    end
  end
  // edge-sensitive controller latch on the jumpered level only
  always @(posedge clk) begin
    prev_q <= irq_line_oe[lv] & irq_line[lv];
    if (irq_line_oe[lv] && irq_line[lv] && !prev_q) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

// file: tb/tic_timer_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tic_timer_irq_tb_top import tic_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] host_addr = 4'h0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata;
  logic host_send_ready, host_receive_ready;
  logic tx_want = 1'b0;
  logic rx_want = 1'b0;
  logic [8:0] send_word;
  logic send_stb;
  logic [2:0] sel = 3'h2;
  logic [2:0] lv;
  logic [IRQ_LEVELS-1:0] irq_line, irq_line_oe, sys_irq, hot;
  logic [7:0] edge_cnt;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;

  assign lv = sel - 3'h2;
  assign hot = 6'h01 << lv;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tic_timer_irq u_dut (.clk(clk), .rstn(rstn), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_send_ready(host_send_ready), .host_receive_ready(host_receive_ready),
    .send_word(send_word), .send_stb(send_stb), .irq_level_sel(sel),
    .irq_line(irq_line), .irq_line_oe(irq_line_oe));
  tic_sys_model u_sys (.clk(clk), .tx_want(tx_want), .rx_want(rx_want),
    .host_send_ready(host_send_ready), .host_receive_ready(host_receive_ready),
    .level(sel), .irq_line(irq_line), .irq_line_oe(irq_line_oe), .sys_irq(sys_irq),
    .edge_cnt(edge_cnt));

  // ----------------------------------------------------------------
  // host access and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    @(negedge clk);
    d = host_rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  // waits out any standing request first so that only a fresh rise is timed
  task automatic wait_rise(output int t);
    int n;
    n = 0;
    while (irq_line[lv] === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (irq_line[lv] !== 1'b1 && n < 25000) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, irq_line[lv]}, 16'h1);
    t = cyc;
  endtask
  // period between two events, then pending held with enables off, then cleared
  task automatic timer_run(input logic [7:0] on, input logic [7:0] clr, input int exp,
      input logic [7:0] st);
    int t1, t2;
    wr(OFS_IRQ_CONTROL, on);
    wait_rise(t1);
    wr(OFS_IRQ_CONTROL, on & 8'hbf);
    wr(OFS_IRQ_CONTROL, on & 8'hbf & clr);
    wr(OFS_IRQ_CONTROL, on);
    wait_rise(t2);
    chk(16'(t2 - t1), 16'(exp));
    wr(OFS_IRQ_CONTROL, on & 8'hf3);
    rd_chk(OFS_IRQ_STATUS, st);
    chk({10'h0, irq_line}, 16'h0);
    wr(OFS_IRQ_CONTROL, on & 8'hf3 & clr);
    wr(OFS_IRQ_CONTROL, on & 8'hf3);
    rd_chk(OFS_IRQ_STATUS, 8'h00);
  endtask
  // expected interval: count times prescale times one time-base tick
  function automatic int interval_cyc(input int cnt, input int pre, input int tick);
    return cnt * pre * tick;
  endfunction
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog, sized for two long timer A periods plus the rest
  // ----------------------------------------------------------------
  initial begin
    #(95000 * 25);
    errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v, lo, hi;
    logic [3:0] un [3];
    logic [7:0] gate [3];
    int n, p, b;
    int rl [3];
    void'($urandom(5));
    sel = 3'($urandom_range(2, 7));
    un = '{4'h0, 4'h2, 4'h3};
    gate = '{8'h03, 8'h83, 8'hc3};
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(OFS_IRQ_CONTROL, CTRL_RESET);
    chk({4'h0, irq_line_oe, irq_line}, 16'h0);
    wr(OFS_IRQ_STATUS, 8'hff);
    for (int i = 0; i < 3; i++) begin
      wr(un[i], 8'hff);
      rd_chk(un[i], 8'h00);
    end
    v = 8'($urandom_range(0, 63));
    wr(4'(OFS_IRQ_CONTROL + $urandom_range(0, 3)), v);
    for (int a = 8; a < 16; a++) begin
      rd_chk(4'(a), a < 12 ? v : 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom_range(0, 255));
      wr(OFS_IRQ_CONTROL, {3'h0, i[0], 4'h3});
      wr(OFS_HOST_SEND_PORT, v);
      chk({6'h0, send_stb, send_word}, {6'h0, 1'b1, i[0], v});
      @(negedge clk);
      chk({15'h0, send_stb}, 16'h0);
    end
    // bus drive goes on ahead of the unmask
    tx_want = 1'b1;
    n = int'(edge_cnt);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_IRQ_CONTROL, gate[i]);
      repeat (3) @(negedge clk);
      chk({4'h0, irq_line_oe, irq_line}, {4'h0, gate[i][7] ? hot : 6'h0,
        gate[i][6] ? hot : 6'h0});
    end
    chk(16'(int'(edge_cnt) - n), 16'h1);
    for (int i = 0; i < 4; i++) begin
      tx_want = i[0];
      rx_want = i[1];
      repeat (3) @(negedge clk);
      rd_chk(OFS_IRQ_STATUS, {i != 0, 7'h0});
      chk({10'h0, irq_line}, {10'h0, i != 0 ? hot : 6'h0});
      chk({15'h0, sys_irq[lv]}, {15'h0, i != 0});
    end
    tx_want = 1'b0;
    rx_want = 1'b0;
    wr(OFS_IRQ_CONTROL, 8'h80);
    wr(OFS_IRQ_CONTROL, 8'hc4);
    wr(OFS_COUNTER_CONTROL_WORD, 8'h34);
    n = 16'h0100 + $urandom_range(0, 3);
    wr(OFS_TIMER_A_COUNT, 8'(n));
    wr(OFS_TIMER_A_COUNT, 8'(n >> 8));
    timer_run(8'hc5, 8'hfe, interval_cyc(n, 1, TICK_A_CYC), 8'h01);
    wr(OFS_COUNTER_CONTROL_WORD, 8'hb6);
    p = 2 * $urandom_range(1, 2);
    wr(OFS_TIMER_B_PRESCALE, 8'(p));
    wr(OFS_TIMER_B_PRESCALE, 8'h00);
    wr(OFS_COUNTER_CONTROL_WORD, 8'h74);
    b = $urandom_range(2, 4);
    wr(OFS_TIMER_B_COUNT, 8'(b));
    wr(OFS_TIMER_B_COUNT, 8'h00);
    timer_run(8'hca, 8'hfd, interval_cyc(b, p, TICK_B_CYC), 8'h02);
    rl = '{n, b, p};
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      wr(OFS_COUNTER_CONTROL_WORD, 8'(i << 6));
      rd(4'(OFS_TIMER_A_COUNT + i), lo);
      rd(4'(OFS_TIMER_A_COUNT + i), hi);
      chk(16'({hi, lo} <= rl[i] && {hi, lo} != 16'h0), 16'h1);
    end
    final_report();
  end
endmodule

`default_nettype wire
